// File: core/dgc_pkg.sv
// Package of constants and types for the DAC group clear control block.
package dgc_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_CHANNELS = 12;
	localparam int CODE_WIDTH   = 12;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [CODE_WIDTH-1:0]   DATA_RESET  = 12'h000;
	localparam logic [CODE_WIDTH-1:0]   CLEAR_CODE_RESET = 12'h000;
	localparam logic [NUM_CHANNELS-1:0] GROUP_MASK_RESET = 12'hfff;
	localparam logic [1:0]              SYNC_RESET  = 2'h3;

	typedef logic [CODE_WIDTH-1:0] dgc_code_type;

	// One channel write from the register side.
	typedef struct packed {
		logic                    valid;
		logic [3:0]              channel;
		dgc_code_type            code;
	} dgc_write_type;

	// Clear state machine, one-hot.
	typedef enum logic [1:0] {
		DGC_RUN   = 2'b01,
		DGC_CLEAR = 2'b10
	} dgc_state_type;

endpackage

// File: core/dgc_group_clear.sv
// DAC group clear control: data registers, output latches and clear sequencing.
`timescale 1ns/1ps

module dgc_group_clear (
	input  wire logic                                clk,            // System clock, 100 MHz.
	input  wire logic                                reset_n,        // Async reset, active low.
	input  wire logic                                clkEnable,      // Freezes all state when low.
	input  wire logic                                dac_group_clear_n, // Group clear pin, active low.
	input  wire dgc_pkg::dgc_write_type              dataWrite,      // Data register write.
	input  wire logic [dgc_pkg::NUM_CHANNELS-1:0]    channel_sync_load_bit, // Per-channel sync load.
	input  wire logic                                loadStrobe,     // Transfers sync-load channels.
	input  wire logic [dgc_pkg::NUM_CHANNELS-1:0]    groupMask,      // Channels tied to the pin.
	input  wire dgc_pkg::dgc_code_type               clearCode,      // Predefined clear code.
	output logic [dgc_pkg::NUM_CHANNELS*dgc_pkg::CODE_WIDTH-1:0] latchOut, // Output latches.
	output logic [dgc_pkg::NUM_CHANNELS-1:0]         clearActive     // Channel held in clear.
);
	import dgc_pkg::*;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// A write hits one channel only; channel numbers above the last channel
	// match nothing, so such writes are dropped without side effects.
	function automatic logic write_hits(
		input dgc_write_type req,
		input int            channel
	);
		logic hit;
		hit = req.valid && (req.channel == 4'(channel));
		return hit;
	endfunction

	// Next latch value under the normal load rules, used only while the
	// channel is neither held in clear nor being reloaded.
	function automatic dgc_code_type normal_load(
		input dgc_code_type current,
		input dgc_code_type stored,
		input dgc_code_type written,
		input logic         syncMode,
		input logic         strobe,
		input logic         hit
	);
		dgc_code_type result;
		result = current;
		if (syncMode) begin
			if (strobe) begin
				result = stored;
			end
		end else if (hit) begin
			result = written;
		end
		return result;
	endfunction

	// ----------------------------------------
	// Clear input synchroniser
	// ----------------------------------------
	// Stage 0 feeds only stage 1; stage 1 alone drives the state machine.
	// Both stages reset high, so leaving reset never looks like a clear.
	logic [1:0] sync_q;
	logic [1:0] sync_d;

	always_comb begin
		sync_d = clkEnable ? {sync_q[0], dac_group_clear_n} : sync_q;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_q <= SYNC_RESET;
		end else begin
			sync_q <= sync_d;
		end
	end

	// ----------------------------------------
	// Clear state and channel storage
	// ----------------------------------------
	dgc_state_type                     state_q;
	dgc_state_type                     state_d;
	logic [NUM_CHANNELS-1:0]           member_q;
	logic [NUM_CHANNELS-1:0]           member_d;
	dgc_code_type                      data_q  [NUM_CHANNELS];
	dgc_code_type                      data_d  [NUM_CHANNELS];
	dgc_code_type                      latch_q [NUM_CHANNELS];
	dgc_code_type                      latch_d [NUM_CHANNELS];
	logic                              reload;

	// Entry and exit are each decided by stage 1 alone, on exactly one edge.
	always_comb begin
		state_d  = state_q;
		member_d = member_q;
		reload   = 1'b0;
		case (state_q)
			DGC_RUN: begin
				if (!sync_q[1]) begin
					state_d  = DGC_CLEAR;
					member_d = groupMask;
				end
			end
			DGC_CLEAR: begin
				if (sync_q[1]) begin
					state_d  = DGC_RUN;
					reload   = 1'b1;
					member_d = '0;
				end
			end
			default: begin
				state_d  = DGC_RUN;
				member_d = '0;
			end
		endcase
		if (!clkEnable) begin
			state_d  = state_q;
			member_d = member_q;
			reload   = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q  <= DGC_RUN;
			member_q <= '0;
		end else begin
			state_q  <= state_d;
			member_q <= member_d;
		end
	end

	// ----------------------------------------
	// Per-channel load decode
	// ----------------------------------------
	// The group membership is captured on entry, so a mask change during a clear
	// cannot strand a channel at the clear code after release.
	logic [NUM_CHANNELS-1:0]           holdVec;
	logic [NUM_CHANNELS-1:0]           reloadVec;
	logic [NUM_CHANNELS-1:0]           hitVec;

	always_comb begin
		holdVec   = member_d;
		reloadVec = reload ? member_q : '0;
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			hitVec[i] = clkEnable && write_hits(dataWrite, i);
		end
	end

	// ----------------------------------------
	// Channel data registers
	// ----------------------------------------
	// Writes land here in every state; a clear never touches this storage.
	always_comb begin
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			data_d[i] = data_q[i];
			if (hitVec[i]) begin
				data_d[i] = dataWrite.code;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				data_q[i] <= DATA_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				data_q[i] <= data_d[i];
			end
		end
	end

	// ----------------------------------------
	// Output latches
	// ----------------------------------------
	// Priority: clear hold, then release reload, then the normal load rules.
	// The reload takes the stored value without looking at the sync-load
	// bit, so a channel in sync mode does not wait for a strobe after a clear.
	always_comb begin
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			latch_d[i] = latch_q[i];
			if (clkEnable) begin
				if (holdVec[i]) begin
					latch_d[i] = clearCode;
				end else if (reloadVec[i]) begin
					latch_d[i] = data_q[i];
				end else begin
					latch_d[i] = normal_load(latch_q[i], data_q[i], dataWrite.code,
						channel_sync_load_bit[i], loadStrobe, hitVec[i]);
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				latch_q[i] <= DATA_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				latch_q[i] <= latch_d[i];
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Pure wiring of registers: nothing combinational sits in front of the pins.
	always_comb begin
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			latchOut[i*CODE_WIDTH +: CODE_WIDTH] = latch_q[i];
		end
		clearActive = member_q;
	end

endmodule

// File: verif/dgc_clear_source.sv
// External logic that drives the group clear pin.
`timescale 1ns/1ps
module dgc_clear_source (
	input  wire logic clk,       // System clock.
	input  wire logic holdClear, // Bench asks for a clear.
	output logic      clearPin_n // Clear pin, active low.
);
	initial begin
		clearPin_n = 1'b1;
		forever begin
			@(posedge clk);
			clearPin_n <= #1 !holdClear;
		end
	end
endmodule

// File: verif/dgc_group_clear_assertions.sv
// Checker for the group clear block.
`timescale 1ns/1ps
module dgc_group_clear_assertions (
	input wire logic                             clk,                   // Clock.
	input wire logic                             reset_n,               // Reset, active low.
	input wire logic                             clkEnable,             // Clock enable.
	input wire logic                             dac_group_clear_n,     // Clear pin.
	input wire dgc_pkg::dgc_write_type           dataWrite,             // Data write.
	input wire logic [dgc_pkg::NUM_CHANNELS-1:0] channel_sync_load_bit, // Sync bits.
	input wire logic [dgc_pkg::NUM_CHANNELS-1:0] groupMask,             // Group members.
	input wire logic [dgc_pkg::NUM_CHANNELS-1:0] clearActive,           // Held channels.
	input wire dgc_pkg::dgc_code_type            clearCode,             // Clear code.
	input wire logic [dgc_pkg::NUM_CHANNELS*dgc_pkg::CODE_WIDTH-1:0] latchOut // Latches.
);
	import dgc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n || !clkEnable);
	sequence runHigh; dac_group_clear_n[*3]; endsequence
	sequence settledHigh; dac_group_clear_n[*4]; endsequence
	sequence goLow; runHigh ##1 !dac_group_clear_n[*3]; endsequence
	clear_entry_a: assert property (goLow |=> clearActive == $past(groupMask))
		else $error("entry");
	clear_code_a: assert property (clearActive[0] |-> latchOut[11:0] == $past(clearCode))
		else $error("code");
	group_code_a: assert property (clearActive[2] |-> latchOut[35:24] == $past(clearCode))
		else $error("group code");
	clear_hold_a: assert property (!dac_group_clear_n[*3] ##0 clearActive[0]
		|=> clearActive[0]) else $error("hold");
	sync_delay_a: assert property ($changed(clearActive[0])
		|-> $past(dac_group_clear_n, 3) != clearActive[0]) else $error("delay");
	run_quiet_a: assert property (runHigh |=> clearActive == '0)
		else $error("quiet");
	direct_write_a: assert property (settledHigh ##0 dataWrite.valid
		##0 (dataWrite.channel == 4'h0 && !channel_sync_load_bit[0])
		|=> latchOut[11:0] == $past(dataWrite.code)) else $error("write");
endmodule
bind dgc_group_clear dgc_group_clear_assertions chk (.*);

// File: verif/dac_group_clear_control_tb.sv
// Self-checking bench for the group clear block.
`timescale 1ns/1ps
module dac_group_clear_control_tb;
	import dgc_pkg::*;
	logic clk = 0, reset_n = 0, clkEnable = 1, holdClear = 0, clearPin_n, loadStrobe = 0;
	dgc_write_type dataWrite = '0;
	logic [11:0] syncBits = 12'h002, groupMask = 12'h005, clearActive;
	dgc_code_type clearCode = 12'h0a5;
	logic [143:0] latchOut;
	int err_total = 0, checked = 0;
	always #5 clk = ~clk;
	dgc_clear_source src (.clk(clk), .holdClear(holdClear), .clearPin_n(clearPin_n));
	dgc_group_clear dut (.clk(clk), .reset_n(reset_n), .clkEnable(clkEnable),
		.dac_group_clear_n(clearPin_n), .dataWrite(dataWrite), .channel_sync_load_bit(syncBits),
		.loadStrobe(loadStrobe), .groupMask(groupMask), .clearCode(clearCode),
		.latchOut(latchOut), .clearActive(clearActive));
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string what, logic [11:0] seen, logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic strobe;
		loadStrobe = 1'b1;
		cyc(1);
		loadStrobe = 1'b0;
	endtask
	task automatic t_normal;
		dataWrite = '{1'b1, 4'h0, 12'h123};
		cyc(1);
		chk("l0", latchOut[11:0], 12'h123);
		dataWrite = '{1'b1, 4'h1, 12'h456};
		cyc(1);
		dataWrite.valid = 1'b0;
		chk("l1", latchOut[23:12], 12'h000);
		strobe;
		chk("l1s", latchOut[23:12], 12'h456);
		clkEnable = 1'b0;
		dataWrite = '{1'b1, 4'h0, 12'h777};
		cyc(1);
		chk("frz", latchOut[11:0], 12'h123);
		clkEnable = 1'b1;
		dataWrite.valid = 1'b0;
		cyc(1);
		chk("frz2", latchOut[11:0], 12'h123);
	endtask
	task automatic t_clear;
		syncBits = 12'h003;
		holdClear = 1'b1;
		cyc(5);
		chk("act", clearActive, 12'h005);
		strobe;
		chk("clr", latchOut[11:0], 12'h0a5);
		chk("clr2", latchOut[35:24], 12'h0a5);
		chk("out", latchOut[23:12], 12'h456);
		holdClear = 1'b0;
		cyc(5);
		chk("rel", clearActive, 12'h000);
		chk("back", latchOut[11:0], 12'h123);
		chk("back2", latchOut[35:24], 12'h000);
	endtask
	task automatic test_done;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		cyc(16);
		reset_n = 1'b1;
		cyc(4);
		t_normal;
		t_clear;
		test_done;
	end
	initial begin
		#5000;
		err_total++;
		test_done;
	end
endmodule
